// File: inc/dbc_pkg.sv
// Package for the dual bridge chopping and fault controller.
// Assumes a single 250 MHz core clock; all times become cycle counts here.
package dbc_pkg;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int CLK_MHZ          = 250;
   localparam int PWM_FREQ_KHZ     = 50;
   localparam int PWM_PERIOD_CYC   = CLK_MHZ * 1000 / PWM_FREQ_KHZ;
   localparam int DEAD_NS          = 450;
   localparam int DEAD_CYC         = (DEAD_NS * CLK_MHZ + 999) / 1000;
   localparam int BLANK_NS         = 3750;
   localparam int BLANK_CYC        = (BLANK_NS * CLK_MHZ + 999) / 1000;
   localparam int DEGLITCH_NS      = 4000;
   localparam int DEGLITCH_CYC     = (DEGLITCH_NS * CLK_MHZ + 999) / 1000;
   localparam int RETRY_US_X100    = 135000;
   localparam int RETRY_CYC        = RETRY_US_X100 / 100 * CLK_MHZ;
   localparam int WAKE_US          = 1000;
   localparam int WAKE_CYC         = WAKE_US * CLK_MHZ;
   localparam int CNT_W            = 20;

   // Reset values.
   localparam logic [1:0] GATE_OFF = 2'h0;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      DBC_COAST   = 2'b00,
      DBC_FORWARD = 2'b01,
      DBC_REVERSE = 2'b10,
      DBC_BRAKE   = 2'b11
   } dbc_cmd_t;

   // Gate drive of one bridge: high side and low side of each leg.
   typedef struct packed {
      logic hs_first;
      logic ls_first;
      logic hs_second;
      logic ls_second;
   } dbc_gate_t;

   // Per-bridge sensed analog status, already digital comparator outputs.
   typedef struct packed {
      logic sense_trip;
      logic hs_limit;
      logic ls_limit;
   } dbc_sense_t;

endpackage

// File: verilog/dbc_bridge.sv
// One H-bridge: command decode, current chopping, dead time, overcurrent.
// Assumes synchronised inputs and a pwm_start pulse common to both bridges.
`timescale 1ns/1ps
module dbc_bridge #(
   parameter int RETRY_CYCLES = dbc_pkg::RETRY_CYC
) (
   // Clock and reset
   input  wire logic                clk_in,
   input  wire logic                rst_n_in,
   // Control
   input  wire logic                run_in,
   input  wire logic                pwm_start_in,
   input  wire logic                bridge_ctrl_first_in,
   input  wire logic                bridge_ctrl_second_in,
   input  wire dbc_pkg::dbc_sense_t sense_in,
   // Results
   output      dbc_pkg::dbc_gate_t  gate_out,
   output      logic                ocp_fault_out
);
   import dbc_pkg::*;

   typedef enum logic [1:0] {
      DBC_ST_DRIVE = 2'b00,
      DBC_ST_DECAY = 2'b01,
      DBC_ST_OCP   = 2'b10
   } dbc_bst_t;

   dbc_bst_t          st_r, st_nxt;
   logic [CNT_W-1:0]  blank_r, blank_nxt;
   logic [CNT_W-1:0]  deg_r, deg_nxt;
   logic [CNT_W-1:0]  retry_r, retry_nxt;
   logic [CNT_W-1:0]  dead_r, dead_nxt;
   dbc_gate_t         want, gate_r, gate_nxt;
   dbc_cmd_t          cmd;

   // ----------------------------------------------------------------------
   // State and counters
   // ----------------------------------------------------------------------
   // Counters restart on every internal reset, so sleep clears them.
   always_comb begin
      cmd       = dbc_cmd_t'({bridge_ctrl_second_in, bridge_ctrl_first_in});
      st_nxt    = st_r;
      // Blanking reloads until the gates match the request, so the
      // window runs from the moment current flows; counting from the
      // state change would lose the dead time off the minimum on time.
      if (gate_r != want)
         blank_nxt = CNT_W'(BLANK_CYC);
      else
         blank_nxt = (blank_r != '0) ? blank_r - 1'b1 : blank_r;
      deg_nxt   = deg_r;
      retry_nxt = (retry_r != '0) ? retry_r - 1'b1 : retry_r;
      // Limit flags come from the FET limiters, not the sense pin.
      if ((sense_in.hs_limit || sense_in.ls_limit) && st_r != DBC_ST_OCP)
         deg_nxt = deg_r + 1'b1;
      else
         deg_nxt = '0;
      unique case (st_r)
         DBC_ST_DRIVE: begin
            // Trip only after the blanking window; it is also min on time.
            if (blank_r == '0 && sense_in.sense_trip &&
                (cmd == DBC_FORWARD || cmd == DBC_REVERSE))
               st_nxt = DBC_ST_DECAY;
         end
         DBC_ST_DECAY: begin
            if (pwm_start_in) begin
               st_nxt    = DBC_ST_DRIVE;
               blank_nxt = CNT_W'(BLANK_CYC);
            end
         end
         DBC_ST_OCP: begin
            if (retry_r == '0) begin
               st_nxt    = DBC_ST_DRIVE;
               blank_nxt = CNT_W'(BLANK_CYC);
            end
         end
         default: st_nxt = DBC_ST_DRIVE;
      endcase
      if (deg_r >= CNT_W'(DEGLITCH_CYC)) begin
         st_nxt    = DBC_ST_OCP;
         retry_nxt = CNT_W'(RETRY_CYCLES);
         deg_nxt   = '0;
      end
      if (!run_in) begin
         st_nxt    = DBC_ST_DRIVE;
         blank_nxt = CNT_W'(BLANK_CYC);
      end
   end

   // ----------------------------------------------------------------------
   // Gate request and dead time
   // ----------------------------------------------------------------------
   // A leg switching sides passes through all-off for the dead time.
   always_comb begin
      want = '0;
      if (run_in && st_r == DBC_ST_DECAY)
         want = '{hs_first:1'b0, ls_first:1'b1,
                  hs_second:1'b0, ls_second:1'b1};
      else if (run_in && st_r == DBC_ST_DRIVE) begin
         unique case (cmd)
            DBC_COAST:   want = '0;
            DBC_FORWARD: want = '{1'b1, 1'b0, 1'b0, 1'b1};
            DBC_REVERSE: want = '{1'b0, 1'b1, 1'b1, 1'b0};
            DBC_BRAKE:   want = '{1'b0, 1'b1, 1'b0, 1'b1};
         endcase
      end
      gate_nxt = gate_r;
      dead_nxt = (dead_r != '0) ? dead_r - 1'b1 : dead_r;
      if (want != gate_r) begin
         // Turning off is immediate; turning on waits out the dead time.
         if ((want & gate_r) != gate_r) begin
            gate_nxt = want & gate_r;
            dead_nxt = CNT_W'(DEAD_CYC);
         end else if (dead_r == '0)
            gate_nxt = want;
      end
   end

   // OVERCURRENT_GUARD shuts this bridge only; the sibling instance is untouched.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_r    <= DBC_ST_DRIVE;
         blank_r <= CNT_W'(BLANK_CYC);
         deg_r   <= '0;
         retry_r <= '0;
         dead_r  <= '0;
         gate_r  <= '0;
      end else begin
         st_r    <= st_nxt;
         blank_r <= blank_nxt;
         deg_r   <= deg_nxt;
         retry_r <= retry_nxt;
         dead_r  <= dead_nxt;
         gate_r  <= gate_nxt;
      end
   end

   assign gate_out      = gate_r;
   assign ocp_fault_out = (st_r == DBC_ST_OCP);

endmodule

// File: verilog/dbc_top.sv
// Top of the dual bridge chopping and fault controller.
// Assumes pins and analog comparators are asynchronous; one 250 MHz clock.
`timescale 1ns/1ps
module dbc_top #(
   parameter int WAKE_CYCLES  = dbc_pkg::WAKE_CYC,
   parameter int RETRY_CYCLES = dbc_pkg::RETRY_CYC
) (
   // Clock and reset
   input  wire logic                clk_in,
   input  wire logic                arst_n_in,
   // Host pins
   input  wire logic                low_power_request_n_in,
   input  wire logic [1:0]          bridge_ctrl_first_in,
   input  wire logic [1:0]          bridge_ctrl_second_in,
   // Analog comparator results: per bridge, then chip-wide heat and supply
   input  wire dbc_pkg::dbc_sense_t sense_in [2],
   input  wire logic                overtemp_shutdown_in,
   input  wire logic                supply_low_lockout_in,
   // Gate drive and alert
   output      dbc_pkg::dbc_gate_t  gate_out [2],
   output      logic                pump_enable_out,
   output      logic                protection_alert_out_n
);
   import dbc_pkg::*;

   // ----------------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------------
   logic [1:0] rst_sync_r;
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in)
         rst_sync_r <= 2'h0;
      else
         rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   wire rst_n = rst_sync_r[1];

   // ----------------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------------
   localparam int SYN_W = 1 + 2 + 2 + 6 + 2;
   logic [SYN_W-1:0] syn1_r, syn2_r;
   wire  [SYN_W-1:0] raw = {low_power_request_n_in, bridge_ctrl_first_in,
                            bridge_ctrl_second_in, sense_in[1], sense_in[0],
                            overtemp_shutdown_in, supply_low_lockout_in};
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         syn1_r <= '0;
         syn2_r <= '0;
      end else begin
         syn1_r <= raw;
         syn2_r <= syn1_r;
      end
   end
   wire        awake_s  = syn2_r[12];
   wire  [1:0] first_s  = syn2_r[11:10];
   wire  [1:0] second_s = syn2_r[9:8];
   dbc_sense_t sens_s [2];
   assign sens_s[1] = syn2_r[7:5];
   assign sens_s[0] = syn2_r[4:2];
   wire        hot_s    = syn2_r[1];
   wire        supply_low_lockout_s   = syn2_r[0];

   // ----------------------------------------------------------------------
   // Internal reset: sleep or lockout holds the core logic in reset
   // ----------------------------------------------------------------------
   // Sleep and lockout reset the core, asynchronously in the bridges and synchronously in the wake timer and divider; this
   // models stopped clocks without gating the real clock.
   wire core_rst_n = rst_n & awake_s & ~supply_low_lockout_s;

   // ----------------------------------------------------------------------
   // Wake timer and PWM divider
   // ----------------------------------------------------------------------
   logic [CNT_W-1:0] wake_r, wake_nxt;
   logic [CNT_W-1:0] pwm_r, pwm_nxt;
   logic             run_r, run_nxt;
   logic             pwm_start;

   always_comb begin
      wake_nxt  = wake_r;
      run_nxt   = run_r;
      pwm_nxt   = pwm_r;
      pwm_start = 1'b0;
      if (!core_rst_n) begin
         wake_nxt = CNT_W'(WAKE_CYCLES);
         run_nxt  = 1'b0;
         pwm_nxt  = '0;
      end else begin
         if (wake_r != '0)
            wake_nxt = wake_r - 1'b1;
         else
            run_nxt = 1'b1;
         if (pwm_r == CNT_W'(PWM_PERIOD_CYC - 1)) begin
            pwm_nxt   = '0;
            pwm_start = 1'b1;
         end else
            pwm_nxt = pwm_r + 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         wake_r <= '0;
         run_r  <= 1'b0;
         pwm_r  <= '0;
      end else begin
         wake_r <= wake_nxt;
         run_r  <= run_nxt;
         pwm_r  <= pwm_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Bridges
   // ----------------------------------------------------------------------
   // Commands are gated by run; asleep the bridges sit in reset, so nothing is heeded.
   dbc_gate_t br_gate [2];
   logic [1:0] br_ocp;
   wire        bridge_run = run_r & ~hot_s;

   for (genvar b = 0; b < 2; b++) begin : g_br
      dbc_bridge #(
         .RETRY_CYCLES          (RETRY_CYCLES)
      ) u_br (
         .clk_in                (clk_in),
         .rst_n_in              (core_rst_n),
         .run_in                (bridge_run),
         .pwm_start_in          (pwm_start),
         .bridge_ctrl_first_in  (first_s[b]),
         .bridge_ctrl_second_in (second_s[b]),
         .sense_in              (sens_s[b]),
         .gate_out              (br_gate[b]),
         .ocp_fault_out         (br_ocp[b])
      );
   end

   // ----------------------------------------------------------------------
   // Output registers
   // ----------------------------------------------------------------------
   // Lockout pulls the alert low even though the core is in reset.
   dbc_gate_t gate_r [2];
   logic      pump_r;
   logic      alert_n_r;
   logic      alert_n_nxt;

   always_comb begin
      alert_n_nxt = 1'b1;
      if (supply_low_lockout_s && rst_n)
         alert_n_nxt = 1'b0;
      else if (core_rst_n && (hot_s || br_ocp != 2'h0))
         alert_n_nxt = 1'b0;
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         gate_r[0] <= '0;
         gate_r[1] <= '0;
         pump_r    <= 1'b0;
         alert_n_r <= 1'b1;
      end else begin
         // All FETs off in sleep gives the high impedance output.
         gate_r[0] <= core_rst_n ? br_gate[0] : '0;
         gate_r[1] <= core_rst_n ? br_gate[1] : '0;
         pump_r    <= core_rst_n;
         alert_n_r <= alert_n_nxt;
      end
   end

   assign gate_out[0]            = gate_r[0];
   assign gate_out[1]            = gate_r[1];
   assign pump_enable_out        = pump_r;
   assign protection_alert_out_n = alert_n_r;

endmodule

// File: tb/dbc_chk_assertions.sv
// Checker for the bridge controller top; sees only its ports.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module dbc_chk #(
   parameter int WAKE_CYCLES = 50
) (
   input wire logic                clk_in,
   input wire logic                arst_n_in,
   input wire logic                low_power_request_n_in,
   input wire logic [1:0]          bridge_ctrl_first_in,
   input wire logic [1:0]          bridge_ctrl_second_in,
   input wire dbc_pkg::dbc_sense_t sense_in [2],
   input wire logic                overtemp_shutdown_in,
   input wire logic                supply_low_lockout_in,
   input wire dbc_pkg::dbc_gate_t  gate_out [2],
   input wire logic                pump_enable_out,
   input wire logic                protection_alert_out_n
);
   import dbc_pkg::*;
   logic        calm;
   logic        fwd0;
   logic [12:0] quiet_r [2];
   logic [10:0] fwdq_r;
   logic [12:0] fwdoff_r;
   logic [10:0] lim_r;
   logic [10:0] on_r;
   logic [7:0]  lsoff_r;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   function automatic logic [3:0] dec(input logic f, input logic s);
      return f ? (s ? 4'h5 : 4'h9) : (s ? 4'h6 : 4'h0);
   endfunction
   // A calm span has no sleep, heat or lockout.
   assign calm = low_power_request_n_in && !overtemp_shutdown_in
                 && !supply_low_lockout_in;
   assign fwd0 = bridge_ctrl_first_in[0] && !bridge_ctrl_second_in[0];
   // Run lengths, all but fwdoff_r saturating; ceilings sit past every bound used.
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         quiet_r[0] <= '0;
         quiet_r[1] <= '0;
         fwdq_r     <= '0;
         fwdoff_r   <= '0;
         lim_r      <= '0;
         on_r       <= '0;
         lsoff_r    <= 8'hff; // Reset counts as a long off spell.
      end else begin
         quiet_r[0] <= (calm && sense_in[0] == 3'h0
            && $stable(bridge_ctrl_first_in[0])
            && $stable(bridge_ctrl_second_in[0])) ?
            quiet_r[0] + 13'(quiet_r[0] < 13'd7000) : '0;
         quiet_r[1] <= (calm && sense_in[1] == 3'h0
            && $stable(bridge_ctrl_first_in[1])
            && $stable(bridge_ctrl_second_in[1])) ?
            quiet_r[1] + 13'(quiet_r[1] < 13'd7000) : '0;
         fwdq_r <= (calm && fwd0 && !sense_in[0].hs_limit
            && !sense_in[0].ls_limit && $stable(bridge_ctrl_first_in[0])
            && $stable(bridge_ctrl_second_in[0])) ?
            fwdq_r + 11'(fwdq_r < 11'd2000) : '0;
         fwdoff_r <= (fwdq_r >= 11'd1200 && !gate_out[0].hs_first) ?
            fwdoff_r + 13'd1 : '0;
         lim_r <= (sense_in[0].hs_limit || sense_in[0].ls_limit) ?
            lim_r + 11'(lim_r < 11'd2000) : '0;
         on_r <= gate_out[0].hs_first ? on_r + 11'(on_r < 11'd2000) : '0;
         lsoff_r <= gate_out[0].ls_first ? '0 :
            lsoff_r + 8'(lsoff_r != 8'hff);
      end
   end
   // -----------------------------------------------------------------
   // Properties
   // -----------------------------------------------------------------
   property p_sleep_off;
      !low_power_request_n_in [*6] |->
         gate_out[0] == 4'h0 && gate_out[1] == 4'h0 && !pump_enable_out;
   endproperty
   a_sleep_off: assert property (p_sleep_off)
      else $error("bridge or pump live in sleep");
   property p_hot;
      overtemp_shutdown_in [*8] |-> gate_out[0] == 4'h0
         && gate_out[1] == 4'h0 && !protection_alert_out_n;
   endproperty
   a_hot: assert property (p_hot)
      else $error("bridges live while hot");
   property p_low_sup;
      supply_low_lockout_in [*8] |-> gate_out[0] == 4'h0
         && gate_out[1] == 4'h0 && !protection_alert_out_n
         && !pump_enable_out;
   endproperty
   a_low_sup: assert property (p_low_sup)
      else $error("circuits live in lockout");
   property p_ocp_trip;
      lim_r == 11'd1020 |-> gate_out[0] == 4'h0 && !protection_alert_out_n;
   endproperty
   a_ocp_trip: assert property (p_ocp_trip)
      else $error("lasting limit did not shut bridge");
   property p_dead;
      $rose(gate_out[0].hs_first) |-> lsoff_r >= 8'd100;
   endproperty
   a_dead: assert property (p_dead)
      else $error("leg turned on without dead time");
   property p_min_on;
      fwdq_r >= 11'd1200 && $fell(gate_out[0].hs_first) |-> on_r >= 11'd900;
   endproperty
   a_min_on: assert property (p_min_on)
      else $error("drive shorter than blanking");
   property p_period;
      fwdoff_r < 13'd5200;
   endproperty
   a_period: assert property (p_period)
      else $error("chopped bridge off past one cycle");
   for (genvar b = 0; b < 2; b++) begin : g_br
      property p_decode;
         quiet_r[b] == 13'd6000 |-> gate_out[b] ==
            dec(bridge_ctrl_first_in[b], bridge_ctrl_second_in[b]);
      endproperty
      a_decode: assert property (p_decode)
         else $error("gates do not follow command");
      property p_no_shoot;
         !(gate_out[b].hs_first && gate_out[b].ls_first)
            && !(gate_out[b].hs_second && gate_out[b].ls_second);
      endproperty
      a_no_shoot: assert property (p_no_shoot)
         else $error("both switches of one leg on");
   end
   c_sleep: cover property (!low_power_request_n_in [*6]);
   c_trip: cover property (fwdq_r >= 11'd1200 && $fell(gate_out[0].hs_first));
   c_ocp: cover property (lim_r == 11'd1020);
endmodule

bind dbc_top dbc_chk #(.WAKE_CYCLES(WAKE_CYCLES)) u_chk (
   .clk_in(clk_in), .arst_n_in(arst_n_in),
   .low_power_request_n_in(low_power_request_n_in),
   .bridge_ctrl_first_in(bridge_ctrl_first_in),
   .bridge_ctrl_second_in(bridge_ctrl_second_in), .sense_in(sense_in),
   .overtemp_shutdown_in(overtemp_shutdown_in),
   .supply_low_lockout_in(supply_low_lockout_in), .gate_out(gate_out),
   .pump_enable_out(pump_enable_out),
   .protection_alert_out_n(protection_alert_out_n)
);

// File: tb/dbc_host_model.sv
// Host controller model: drives bridge inputs and the sleep request.
// Assumes the bench calls its tasks; pins move on the falling edge.
`timescale 1ns/1ps
module dbc_host_model (
   // Clock
   input  wire logic clk_in,
   // Host pins
   output logic       low_power_request_n_out,
   output logic [1:0] first_out,
   output logic [1:0] second_out
);
   initial begin
      low_power_request_n_out = 1'b1;
      first_out = 2'h0;
      second_out = 2'h0;
   end
   // Changes land mid-cycle, away from the sampling edge.
   task automatic drive(input int b, input logic f, input logic s);
      @(negedge clk_in);
      first_out[b] = f;
      second_out[b] = s;
   endtask
   // Paralleled bridges get one command on both at once.
   task automatic drive_par(input logic f, input logic s);
      @(negedge clk_in);
      first_out = {f, f};
      second_out = {s, s};
   endtask
   // After each change of the sleep request the host waits the given number of cycles.
   task automatic set_sleep(input logic asleep, input int wake);
      @(negedge clk_in);
      low_power_request_n_out = !asleep;
      repeat (wake) @(negedge clk_in);
   endtask
endmodule

// File: tb/tb.sv
// Self-checking bench for the bridge controller top.
// Assumes the host model and the bound checker beside it.
`timescale 1ns/1ps
module tb;
   import dbc_pkg::*;
   localparam int WAKE = 50;
   localparam int RETRY = 400;
   logic       clk_in = 1'b0;
   logic       arst_n = 1'b0;
   logic       sleep_n;
   logic [1:0] first;
   logic [1:0] second;
   dbc_sense_t sense [2] = '{default: '0};
   logic       hot = 1'b0;
   logic       low_sup = 1'b0;
   dbc_gate_t  gates [2];
   logic       pump;
   logic       alert_n;
   int         errors = 0;
   int         checked = 0;
   integer     seed = 32'haeda2338;
   int         n;
   int         v;
   always #2 clk_in = ~clk_in;
   dbc_host_model host (.clk_in(clk_in), .low_power_request_n_out(sleep_n),
      .first_out(first), .second_out(second));
   dbc_top #(.WAKE_CYCLES(WAKE), .RETRY_CYCLES(RETRY)) uut (
      .clk_in(clk_in), .arst_n_in(arst_n),
      .low_power_request_n_in(sleep_n), .bridge_ctrl_first_in(first),
      .bridge_ctrl_second_in(second), .sense_in(sense),
      .overtemp_shutdown_in(hot), .supply_low_lockout_in(low_sup),
      .gate_out(gates), .pump_enable_out(pump),
      .protection_alert_out_n(alert_n));
   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   task automatic give_verdict();
      if (errors == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic chk2(input string what, input logic [3:0] e0, e1);
      check(what, gates[0], e0);
      check(what, gates[1], e1);
   endtask
   // Bench model of the input decode, in plain integers.
   function automatic logic [3:0] model(input int f, input int s);
      return (f != 0 && s == 0) ? 4'h9 : (f == 0 && s != 0) ? 4'h6 :
         (f != 0) ? 4'h5 : 4'h0;
   endfunction
   task automatic cyc(input int k);
      repeat (k) @(negedge clk_in);
   endtask
   // Bounded wait on the first high side of bridge 0; n counts cycles.
   task automatic wait_hs(input logic lvl);
      n = 0;
      while (gates[0].hs_first !== lvl && n < 6000) begin
         @(negedge clk_in);
         n++;
      end
      if (n >= 6000) begin
         errors++;
         give_verdict();
      end
   endtask
   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   initial begin
      cyc(5);
      arst_n = 1'b1;
      cyc(WAKE + 20);
      // All codes on both bridges, then random ones.
      for (int i = 0; i < 24; i++) begin
         v = (i < 16) ? i : $random(seed);
         host.drive(0, v[0], v[1]);
         host.drive(1, v[2], v[3]);
         cyc(300);
         chk2("decode", model(v[0], v[1]), model(v[2], v[3]));
      end
      host.drive(0, 1'b1, 1'b0);
      host.set_sleep(1'b1, 10);
      chk2("sleep gates", 4'h0, 4'h0);
      check("sleep pump", pump, 0);
      host.drive_par(1'b0, 1'b1);
      cyc(20);
      chk2("sleep inputs", 4'h0, 4'h0);
      host.set_sleep(1'b0, WAKE / 2);
      chk2("wake gates", 4'h0, 4'h0);
      cyc(WAKE + 300);
      chk2("awake gates", 4'h6, 4'h6);
      // Chop bridge 0 while bridge 1 drives on untouched.
      host.drive_par(1'b1, 1'b0);
      cyc(1200);
      sense[0].sense_trip = 1'b1;
      wait_hs(1'b0);
      wait_hs(1'b1);
      wait_hs(1'b0);
      v = n;
      check("min on", v >= BLANK_CYC, 1);
      cyc(200);
      chk2("slow decay", 4'h5, 4'h9);
      wait_hs(1'b1);
      check("pwm period", v + 200 + n, PWM_PERIOD_CYC);
      sense[0].sense_trip = 1'b0;
      cyc(200);
      hot = 1'b1;
      cyc(20);
      chk2("hot gates", 4'h0, 4'h0);
      check("hot alert", alert_n, 0);
      hot = 1'b0;
      wait_hs(1'b1);
      cyc(150);
      chk2("cool gates", 4'h9, 4'h9);
      check("cool alert", alert_n, 1);
      low_sup = 1'b1;
      cyc(20);
      chk2("lockout gates", 4'h0, 4'h0);
      check("lockout alert", alert_n, 0);
      check("lockout pump", pump, 0);
      low_sup = 1'b0;
      wait_hs(1'b1);
      cyc(150);
      chk2("supply back", 4'h9, 4'h9);
      // Lasting limit on one bridge, sense path quiet.
      for (int b = 0; b < 2; b++) begin
         host.drive(b, 1'b1, 1'b0);
         host.drive(1 - b, 1'b0, 1'b1);
         cyc(300);
         sense[b].hs_limit = (b == 0);
         sense[b].ls_limit = (b == 1);
         cyc(1100);
         check("ocp gates", gates[b], 0);
         check("ocp alert", alert_n, 0);
         check("ocp other", gates[1 - b], 4'h6);
         cyc(RETRY);
         check("retry alert", alert_n, 1);
         check("retry gates", gates[b], 4'h9);
         cyc(1100);
         check("retry again", gates[b], 0);
         check("retry alert low", alert_n, 0);
         check("retry other", gates[1 - b], 4'h6);
         sense = '{default: '0};
         arst_n = 1'b0;
         cyc(2);
         arst_n = 1'b1;
         cyc(300);
         check("ocp cleared", alert_n, 1);
         check("ocp resumed", gates[b], 4'h9);
      end
      give_verdict();
   end
endmodule
